//--- hw/scl_pkg.sv
// Constants and carrier types for the service counter and log block
package scl_pkg;
  localparam int DATA_DEPTH = 20;
  localparam int FAULT_DEPTH = 10;
  localparam int CLK_HZ = 50000000;
  localparam int LOG_PERIOD_MS = 160;
  localparam int LOG_PERIOD_CYC = CLK_HZ / 1000 * LOG_PERIOD_MS;
  localparam logic [13:0] EVENT_COUNT_MAX = 14'd9999;
  localparam logic [6:0] TRIP_CAUSE_MAX = 7'd99;
  localparam logic [13:0] TRIP_VALUE_MAX = 14'd9999;
  localparam logic [20:0] HOURS_MAX = 21'd1300000;
  localparam logic [6:0] REFERENCE_MAX = 7'd100;
  localparam logic [31:0] ENERGY_MAX = 32'hffff_ffff;
  localparam logic [3:0] OVERVOLT_ALARM = 4'h7;
  localparam int SEL_DATA_W = 5;
  localparam int SEL_FAULT_W = 4;
  localparam logic [SEL_DATA_W-1:0] DATA_INDEX_FIRST = 5'h01;
  localparam logic [SEL_FAULT_W-1:0] FAULT_INDEX_FIRST = 4'h1;
  localparam logic SELECT_RESET = 1'b1;

  // One data log sample
  typedef struct packed {
    logic [7:0] digitalInput;
    logic [15:0] controlWord;
    logic [15:0] statusWord;
    logic [7:0] reference;
    logic [31:0] feedback;
    logic [15:0] outputFrequency;
    logic [15:0] outputVoltage;
    logic [15:0] outputCurrent;
    logic [15:0] linkVoltage;
  } scl_sample_t;

  // One fault log entry
  typedef struct packed {
    logic [7:0] tripCause;
    logic [31:0] tripHours;
    logic [13:0] tripValue;
  } scl_fault_t;

  typedef enum logic [1:0] {
    SCL_IDLE,
    SCL_LOGGING,
    SCL_FROZEN
  } scl_state_t;
endpackage

//--- hw/scl_service_log.sv
// Service counters, rolling data log, fault log and counter clearing
// Function
// R1 - Count every supply cut-in and make the count readable.
// R2 - Count every heat-sink overtemperature error.
// R3 - Overvoltage counter advances only while alarm 7 is active.
// R4 - Data log keeps 20 entries, index 1 newest, 20 oldest.
// R5 - After start, log every quantity every 160 ms.
// R6 - Trip or stop halts logging and keeps latest 20 entries readable.
// R7 - Digital input pattern: first input bit 7 (128), last bit 0 (1).
// R8 - Third input weighs 32, fifth input weighs 8.
// R9 - Control and status words logged as 16-bit unsigned values.
// R10 - Logged control word changes only through the serial interface.
// R11 - Log reference 0-100 %, feedback, frequency, voltage, current, link voltage.
// R12 - Each trip stores code 0-99 in 10-entry log, index 1 newest.
// R13 - Each trip stores hours run, 0 to 130000.0 hours.
// R14 - Each trip stores trip value limited to 0-9999.
// R15 - Fault logs clear only on manual initialisation.
// R16 - Energy clear selector defaults 0; 1 plus confirm clears energy counter.
// R17 - Hours clear selector defaults 0; 1 plus confirm clears hours run.
// R18 - Serial writes to either clear selector are rejected.
// R19 - Energy counter accumulates hourly mean power.
// R20 - Each log write shifts entries toward oldest, dropping the oldest.
// R21 - Counters saturate at their maximum, never wrap.
`timescale 1ns/10ps
module scl_service_log
  import scl_pkg::*;
#(
  parameter int LOG_CYCLES = LOG_PERIOD_CYC,
  parameter int DEPTH = DATA_DEPTH,
  parameter int FDEPTH = FAULT_DEPTH
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic supplyCutIn,
  input wire logic heatSinkOverTemp,
  input wire logic [3:0] activeAlarm,
  input wire logic overVoltEvent,
  input wire logic startCmd,
  input wire logic motorStopped,
  input wire logic tripEvent,
  input wire logic [6:0] tripCause,
  input wire logic [13:0] tripValue,
  input wire logic [7:0] inputTerminals,
  input wire logic serialCtrlWrite,
  input wire logic [15:0] serialCtrlData,
  input wire logic [15:0] statusWord,
  input wire logic [7:0] referencePct,
  input wire logic [31:0] feedback,
  input wire logic [15:0] outputFrequency,
  input wire logic [15:0] outputVoltage,
  input wire logic [15:0] outputCurrent,
  input wire logic [15:0] linkVoltage,
  input wire logic hourTick,
  input wire logic [31:0] hourMeanEnergy,
  input wire logic motorRunning,
  input wire logic manualInit,
  input wire logic panelSelWrite,
  input wire logic serialSelWrite,
  input wire logic selEnergy,
  input wire logic energy_counter_clear,
  input wire logic hours_run_clear,
  input wire logic confirmKey,
  input wire logic [SEL_DATA_W-1:0] dataIndex,
  input wire logic [SEL_FAULT_W-1:0] faultIndex,
  output logic [13:0] cutInCount,
  output logic [13:0] overTempCount,
  output logic [13:0] overVoltCount,
  output logic [31:0] energyCount,
  output logic [20:0] hoursRun,
  output logic energyClearSel,
  output logic hoursClearSel,
  output logic logActive,
  output scl_sample_t dataEntry,
  output scl_fault_t faultEntry
);

  // ----------------------------------------------------------------
  // Event counters
  // ----------------------------------------------------------------
  logic [31:0] hourTenth;

  // Saturating counters so a long-lived unit never reads back a small count
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cutInCount <= '0;
      overTempCount <= '0;
      overVoltCount <= '0;
    end else begin
      if (supplyCutIn && cutInCount != EVENT_COUNT_MAX) begin
        cutInCount <= cutInCount + 14'd1; // see R1 see R21
      end
      if (heatSinkOverTemp && overTempCount != EVENT_COUNT_MAX) begin
        overTempCount <= overTempCount + 14'd1; // see R2
      end
      if (overVoltEvent && activeAlarm == OVERVOLT_ALARM
          && overVoltCount != EVENT_COUNT_MAX) begin
        overVoltCount <= overVoltCount + 14'd1; // see R3
      end
    end
  end

  // ----------------------------------------------------------------
  // Clear selectors, panel only
  // ----------------------------------------------------------------
  // Serial writes are dropped; selector falls back once the clear is done
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      energyClearSel <= 1'b0;
      hoursClearSel <= 1'b0;
    end else if (confirmKey) begin
      energyClearSel <= 1'b0; // see R16
      hoursClearSel <= 1'b0; // see R17
    end else if (panelSelWrite) begin
      if (selEnergy) begin
        energyClearSel <= energy_counter_clear;
      end else begin
        hoursClearSel <= hours_run_clear;
      end
    end else if (serialSelWrite) begin
      energyClearSel <= energyClearSel; // see R18
    end
  end

  // Energy accumulation per hour, cleared by confirmed selection
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      energyCount <= '0;
    end else if (confirmKey && energyClearSel == SELECT_RESET) begin
      energyCount <= '0; // see R16
    end else if (hourTick) begin
      if (ENERGY_MAX - energyCount < hourMeanEnergy) begin
        energyCount <= ENERGY_MAX; // see R21
      end else begin
        energyCount <= energyCount + hourMeanEnergy; // see R19
      end
    end
  end

  // Hours run in tenths, advanced by the hour tick while the motor runs
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      hoursRun <= '0;
    end else if (confirmKey && hoursClearSel == SELECT_RESET) begin
      hoursRun <= '0; // see R17
    end else if (hourTick && motorRunning) begin
      if (hoursRun > HOURS_MAX - 21'd10) begin
        hoursRun <= HOURS_MAX; // see R21
      end else begin
        hoursRun <= hoursRun + 21'd10;
      end
    end
  end
  assign hourTenth = {11'd0, hoursRun};

  // ----------------------------------------------------------------
  // Logging control and 160 ms pacing
  // ----------------------------------------------------------------
  scl_state_t state;
  logic [31:0] periodCnt;
  logic logStrobe;
  logic [15:0] controlWord;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state <= SCL_IDLE;
    end else begin
      unique case (state)
        SCL_IDLE, SCL_FROZEN: begin
          if (startCmd && !tripEvent) begin
            state <= SCL_LOGGING; // see R5
          end
        end
        SCL_LOGGING: begin
          if (tripEvent || motorStopped) begin
            state <= SCL_FROZEN; // see R6
          end
        end
      endcase
    end
  end

  // Divider gives one-cycle strobe per period; first sample after a full period
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      periodCnt <= '0;
      logStrobe <= 1'b0;
    end else if (state != SCL_LOGGING || tripEvent || motorStopped) begin
      periodCnt <= '0;
      logStrobe <= 1'b0;
    end else if (periodCnt == 32'(LOG_CYCLES - 1)) begin
      periodCnt <= '0;
      logStrobe <= 1'b1; // see R5
    end else begin
      periodCnt <= periodCnt + 32'd1;
      logStrobe <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      logActive <= 1'b0;
    end else begin
      logActive <= (state == SCL_LOGGING);
    end
  end

  // Control word held here; only the serial side may change it
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      controlWord <= '0;
    end else if (serialCtrlWrite) begin
      controlWord <= serialCtrlData; // see R10
    end
  end

  // ----------------------------------------------------------------
  // Data log shift array
  // ----------------------------------------------------------------
  scl_sample_t dataLog [DEPTH];
  scl_sample_t newSample;

  // Pack the live values; terminals already arrive first-input-in-MSB
  always_comb begin
    newSample.digitalInput = inputTerminals; // see R7 see R8
    newSample.controlWord = controlWord; // see R9
    newSample.statusWord = statusWord; // see R9
    newSample.reference = (referencePct > {1'b0, REFERENCE_MAX}) ?
      {1'b0, REFERENCE_MAX} : referencePct; // see R11
    newSample.feedback = feedback;
    newSample.outputFrequency = outputFrequency;
    newSample.outputVoltage = outputVoltage;
    newSample.outputCurrent = outputCurrent;
    newSample.linkVoltage = linkVoltage;
  end

  // Log memory has no reset: a trip's history must survive the event
  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi++) begin : gDataLog
      // Head and tail split so no element ever names index minus one
      if (gi == 0) begin : gHead
        always_ff @(posedge clk_sys) begin
          if (logStrobe) begin
            dataLog[gi] <= newSample; // see R4
          end
        end
      end else begin : gTail
        always_ff @(posedge clk_sys) begin
          if (logStrobe) begin
            dataLog[gi] <= dataLog[gi-1]; // see R20
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Fault log shift array
  // ----------------------------------------------------------------
  scl_fault_t faultLog [FDEPTH];
  scl_fault_t newFault;

  always_comb begin
    newFault.tripCause = {1'b0, (tripCause > TRIP_CAUSE_MAX) ?
      TRIP_CAUSE_MAX : tripCause}; // see R12
    newFault.tripHours = hourTenth; // see R13
    newFault.tripValue = (tripValue > TRIP_VALUE_MAX) ?
      TRIP_VALUE_MAX : tripValue; // see R14
  end

  // Only manual initialisation clears it, never the system reset
  generate
    for (gi = 0; gi < FDEPTH; gi++) begin : gFaultLog
      if (gi == 0) begin : gHead
        always_ff @(posedge clk_sys) begin
          if (manualInit) begin
            faultLog[gi] <= '0; // see R15
          end else if (tripEvent) begin
            faultLog[gi] <= newFault; // see R12
          end
        end
      end else begin : gTail
        always_ff @(posedge clk_sys) begin
          if (manualInit) begin
            faultLog[gi] <= '0; // see R15
          end else if (tripEvent) begin
            faultLog[gi] <= faultLog[gi-1]; // see R20
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Indexed read-out, index 1 is newest
  // ----------------------------------------------------------------
  function automatic logic inRange(input logic [7:0] idx, input int depth);
    inRange = (idx >= 8'd1) && (idx <= 8'(depth));
  endfunction

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      dataEntry <= '0;
      faultEntry <= '0;
    end else begin
      if (inRange({3'd0, dataIndex}, DEPTH)) begin
        dataEntry <= dataLog[dataIndex - DATA_INDEX_FIRST]; // see R4
      end else begin
        dataEntry <= '0;
      end
      if (inRange({4'd0, faultIndex}, FDEPTH)) begin
        faultEntry <= faultLog[faultIndex - FAULT_INDEX_FIRST]; // see R12
      end else begin
        faultEntry <= '0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_cutin_count: assert property (@(posedge clk_sys) disable iff (reset) // see R1
    supplyCutIn && cutInCount < EVENT_COUNT_MAX |=> cutInCount == $past(cutInCount) + 14'd1)
    else $error("cut-in count missed");
  chk_overtemp_count: assert property (@(posedge clk_sys) disable iff (reset) // see R2
    heatSinkOverTemp && overTempCount < EVENT_COUNT_MAX
      |=> overTempCount == $past(overTempCount) + 14'd1)
    else $error("overtemp count missed");
  chk_overvolt_gate: assert property (@(posedge clk_sys) disable iff (reset) // see R3
    activeAlarm != OVERVOLT_ALARM |=> overVoltCount == $past(overVoltCount))
    else $error("overvolt counted without alarm");
  chk_count_saturate: assert property (@(posedge clk_sys) disable iff (reset) // see R21
    cutInCount == EVENT_COUNT_MAX |=> cutInCount == EVENT_COUNT_MAX)
    else $error("counter wrapped");
  chk_frozen_nolog: assert property (@(posedge clk_sys) disable iff (reset) // see R6
    state == SCL_FROZEN |-> !logStrobe)
    else $error("log written while frozen");
  chk_log_shift: assert property (@(posedge clk_sys) disable iff (reset) // see R20
    logStrobe |=> dataLog[1] === $past(dataLog[0]) && dataLog[0] == $past(newSample))
    else $error("log shift wrong");
  chk_fault_shift: assert property (@(posedge clk_sys) disable iff (reset) // see R12
    tripEvent && !manualInit |=> faultLog[0] == $past(newFault))
    else $error("fault entry not stored");
  chk_energy_clear: assert property (@(posedge clk_sys) disable iff (reset) // see R16
    confirmKey && energyClearSel |=> energyCount == 32'h0 && !energyClearSel)
    else $error("energy clear failed");
  chk_hours_clear: assert property (@(posedge clk_sys) disable iff (reset) // see R17
    confirmKey && hoursClearSel |=> hoursRun == 21'h0 && !hoursClearSel)
    else $error("hours clear failed");
  chk_serial_sel: assert property (@(posedge clk_sys) disable iff (reset) // see R18
    serialSelWrite && !panelSelWrite && !confirmKey |=> $stable(energyClearSel)
      && $stable(hoursClearSel))
    else $error("serial changed selector");
  chk_ctrl_serial: assert property (@(posedge clk_sys) disable iff (reset) // see R10
    !serialCtrlWrite |=> $stable(controlWord))
    else $error("control word changed");
  // Stop or trip must freeze at once so the last samples survive
  chk_stop_freezes: assert property (@(posedge clk_sys) disable iff (reset) // see R6
    state == SCL_LOGGING && (tripEvent || motorStopped)
      |=> state == SCL_FROZEN && !logStrobe)
    else $error("log not frozen on stop");
  chk_strobe_running: assert property (@(posedge clk_sys) disable iff (reset) // see R5
    logStrobe |-> state == SCL_LOGGING)
    else $error("log written while not running");
  chk_ref_clamp: assert property (@(posedge clk_sys) disable iff (reset) // see R11
    logStrobe |=> dataLog[0].reference <= {1'b0, REFERENCE_MAX})
    else $error("reference above full scale");
  chk_trip_clamp: assert property (@(posedge clk_sys) disable iff (reset) // see R14
    tripEvent && !manualInit |=> faultLog[0].tripCause <= {1'b0, TRIP_CAUSE_MAX}
      && faultLog[0].tripValue <= TRIP_VALUE_MAX)
    else $error("trip entry out of range");
  chk_hours_saturate: assert property (@(posedge clk_sys) disable iff (reset) // see R21
    hoursRun <= HOURS_MAX)
    else $error("hours run above maximum");

  cov_log_write: cover property (@(posedge clk_sys) disable iff (reset) logStrobe);
  cov_freeze: cover property (@(posedge clk_sys) disable iff (reset)
    state == SCL_LOGGING ##1 state == SCL_FROZEN);
  cov_trip: cover property (@(posedge clk_sys) disable iff (reset) tripEvent);
  cov_energy_clr: cover property (@(posedge clk_sys) disable iff (reset)
    confirmKey && energyClearSel);

endmodule

//--- verif/scl_panel_model.sv
// Operator panel and serial master model for selector and control writes
`timescale 1ns/10ps
module scl_panel_model
  import scl_pkg::*;
(
  input wire logic clk_sys,
  output logic panelSelWrite,
  output logic serialSelWrite,
  output logic selEnergy,
  output logic energy_counter_clear,
  output logic hours_run_clear,
  output logic confirmKey,
  output logic serialCtrlWrite,
  output logic [15:0] serialCtrlData
);
  // ------------------------------------------
  // Requests, each launched at a falling edge
  // ------------------------------------------
  // Idle levels before the first request
  initial begin
    panelSelWrite = 1'b0;
    serialSelWrite = 1'b0;
    selEnergy = 1'b0;
    energy_counter_clear = 1'b0;
    hours_run_clear = 1'b0;
    confirmKey = 1'b0;
    serialCtrlWrite = 1'b0;
    serialCtrlData = 16'h0000;
  end

  // Panel sets one selector; released lines show inverted values
  task automatic panel_select(input logic energy);
    @(negedge clk_sys);
    panelSelWrite = 1'b1;
    selEnergy = energy;
    energy_counter_clear = energy;
    hours_run_clear = ~energy;
    @(negedge clk_sys);
    panelSelWrite = 1'b0;
    selEnergy = ~energy;
    energy_counter_clear = ~energy;
    hours_run_clear = energy;
  endtask

  // OK key, one cycle long
  task automatic confirm();
    @(negedge clk_sys);
    confirmKey = 1'b1;
    @(negedge clk_sys);
    confirmKey = 1'b0;
  endtask

  // Serial master tries to set both selectors
  task automatic serial_select();
    @(negedge clk_sys);
    serialSelWrite = 1'b1;
    energy_counter_clear = 1'b1;
    hours_run_clear = 1'b1;
    @(negedge clk_sys);
    serialSelWrite = 1'b0;
    energy_counter_clear = 1'b0;
    hours_run_clear = 1'b0;
  endtask

  // Serial control word write, the only source of that word
  task automatic serial_ctrl(input logic [15:0] data);
    @(negedge clk_sys);
    serialCtrlWrite = 1'b1;
    serialCtrlData = data;
    @(negedge clk_sys);
    serialCtrlWrite = 1'b0;
    serialCtrlData = ~data;
  endtask
endmodule

//--- verif/tb.sv
// Self-checking bench for the service counter and log block
`timescale 1ns/10ps
module tb;
  import scl_pkg::*;
  localparam int LC = 8;
  typedef struct packed {
    logic cut; logic hot; logic volt; logic [3:0] alarm;
    logic [13:0] eCut; logic [13:0] eHot; logic [13:0] eVolt;
  } scl_row_t;
  // Rows: overvoltage counts only together with alarm 7
  scl_row_t rows [4] = '{
    '{1'b1, 1'b0, 1'b0, 4'h0, 14'h1, 14'h0, 14'h0},
    '{1'b0, 1'b1, 1'b0, 4'h7, 14'h1, 14'h1, 14'h0},
    '{1'b0, 1'b0, 1'b1, 4'h6, 14'h1, 14'h1, 14'h0},
    '{1'b1, 1'b0, 1'b1, 4'h7, 14'h2, 14'h1, 14'h1}};
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic supplyCutIn, heatSinkOverTemp, overVoltEvent, startCmd, motorStopped;
  logic tripEvent, hourTick, motorRunning, manualInit;
  logic panelSelWrite, serialSelWrite, selEnergy, energy_counter_clear;
  logic hours_run_clear, confirmKey, serialCtrlWrite, energyClearSel;
  logic hoursClearSel, logActive;
  logic [3:0] activeAlarm, faultIndex;
  logic [6:0] tripCause;
  logic [13:0] tripValue, cutInCount, overTempCount, overVoltCount;
  logic [7:0] inputTerminals, referencePct;
  logic [15:0] serialCtrlData, statusWord, outputFrequency, outputVoltage;
  logic [15:0] outputCurrent, linkVoltage;
  logic [31:0] feedback, hourMeanEnergy, energyCount;
  logic [20:0] hoursRun;
  logic [4:0] dataIndex;
  scl_sample_t dataEntry, smpA, smpB;
  scl_fault_t faultEntry, fltNew, fltOld;
  int badCount = 0;
  int nChecks = 0;

  scl_service_log #(.LOG_CYCLES(LC)) i_scl_service_log (.*);
  scl_panel_model i_scl_panel_model (.*);

  // Clock, 20 ns period
  always #10 clk_sys = ~clk_sys;

  // -------------------
  // Shared tasks
  // -------------------
  task automatic check(input logic [159:0] seen, input logic [159:0] exp);
    nChecks++;
    if (seen !== exp) begin
      badCount++;
      $display("[ERR] %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d, mismatches %0d", nChecks, badCount);
    if (badCount == 0 && nChecks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  // One start, at least one write, then a stop that freezes the log
  task automatic run_log();
    startCmd = 1'b1;
    cyc(1);
    startCmd = 1'b0;
    cyc(LC + 4);
    check(logActive, 1'b1);
    motorStopped = 1'b1;
    cyc(1);
    motorStopped = 1'b0;
    cyc(2);
  endtask

  // Reads are registered, so the answer is looked at two edges on
  task automatic read_data(input logic [4:0] idx, input scl_sample_t exp);
    dataIndex = idx;
    cyc(2);
    check(dataEntry, exp);
  endtask

  task automatic read_fault(input logic [3:0] idx, input scl_fault_t exp);
    faultIndex = idx;
    cyc(2);
    check(faultEntry, exp);
  endtask

  task automatic trip(input logic [6:0] c, input logic [13:0] v);
    tripCause = c;
    tripValue = v;
    tripEvent = 1'b1;
    cyc(1);
    tripEvent = 1'b0;
    cyc(1);
  endtask

  // Long runs stop here; the tests need about 10100 cycles
  initial begin
    #(40000 * 20);
    badCount++;
    stop_test();
  end

  // -------------------
  // Main sequence
  // -------------------
  initial begin
    {supplyCutIn, heatSinkOverTemp, overVoltEvent, startCmd} = 4'h0;
    {motorStopped, tripEvent, hourTick, motorRunning, manualInit} = 5'h00;
    {activeAlarm, faultIndex, dataIndex, tripCause, tripValue} = '0;
    smpA = '{8'h28, 16'hbeef, 16'h1234, 8'h64, 32'h89abcdef,
      16'h01f4, 16'h0190, 16'h0023, 16'h0226};
    smpB = smpA;
    smpB.digitalInput = 8'h81;
    smpB.controlWord = 16'h0042;
    smpB.reference = 8'h32;
    {statusWord, feedback} = {smpA.statusWord, smpA.feedback};
    {outputFrequency, outputVoltage} = {smpA.outputFrequency, smpA.outputVoltage};
    {outputCurrent, linkVoltage} = {smpA.outputCurrent, smpA.linkVoltage};
    inputTerminals = smpA.digitalInput;
    referencePct = 8'hc8;
    hourMeanEnergy = 32'h00000064;
    cyc(8);
    reset = 1'b0;
    cyc(1);
    check({energyClearSel, hoursClearSel, cutInCount}, '0);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      {supplyCutIn, heatSinkOverTemp} = {rows[i].cut, rows[i].hot};
      {overVoltEvent, activeAlarm} = {rows[i].volt, rows[i].alarm};
      cyc(1);
      {supplyCutIn, heatSinkOverTemp, overVoltEvent} = 3'h0;
      cyc(1);
      check(cutInCount, rows[i].eCut);
      check(overTempCount, rows[i].eHot);
      check(overVoltCount, rows[i].eVolt);
    end
    $display("test event rows done");
    // Two runs, newest first, frozen after the stop
    i_scl_panel_model.serial_ctrl(smpA.controlWord);
    run_log();
    i_scl_panel_model.serial_ctrl(smpB.controlWord);
    inputTerminals = smpB.digitalInput;
    referencePct = smpB.reference;
    run_log();
    cyc(3 * LC);
    check(logActive, 1'b0);
    read_data(5'h01, smpB);
    read_data(5'h02, smpA);
    read_data(5'h15, '0);
    $display("test data log done");
    // Fault log with clamped cause and value
    manualInit = 1'b1;
    cyc(1);
    manualInit = 1'b0;
    motorRunning = 1'b1;
    hourTick = 1'b1;
    cyc(1);
    hourTick = 1'b0;
    trip(7'h05, 14'h0100);
    trip(7'h7f, 14'h3fff);
    fltNew = '{8'h63, 32'h0000000a, 14'h270f};
    fltOld = '{8'h05, 32'h0000000a, 14'h0100};
    read_fault(4'h1, fltNew);
    read_fault(4'h2, fltOld);
    read_fault(4'h3, '0);
    $display("test fault log done");
    // Clearing: serial refused, panel select then OK
    hourTick = 1'b1;
    cyc(1);
    hourTick = 1'b0;
    cyc(1);
    check(energyCount, 32'h000000c8);
    i_scl_panel_model.serial_select();
    cyc(1);
    check({energyClearSel, hoursClearSel}, 2'h0);
    i_scl_panel_model.panel_select(1'b1);
    check(energyClearSel, 1'b1);
    i_scl_panel_model.confirm();
    check({energyCount, hoursRun}, {32'h0, 21'h000014});
    i_scl_panel_model.panel_select(1'b0);
    check(hoursClearSel, 1'b1);
    i_scl_panel_model.confirm();
    check({hoursRun, hoursClearSel, energyClearSel}, '0);
    read_fault(4'h1, fltNew);
    $display("test clearing done");
    // Saturation, then a reset that leaves the fault log alone
    supplyCutIn = 1'b1;
    cyc(10000);
    supplyCutIn = 1'b0;
    cyc(1);
    check(cutInCount, 14'h270f);
    reset = 1'b1;
    cyc(2);
    reset = 1'b0;
    check(cutInCount, 14'h0);
    read_fault(4'h2, fltOld);
    $display("test saturation and reset done");
    stop_test();
  end
endmodule
